// ==== hdl/trf_tx_request_event_fifo.sv ====
// Transmit request bookkeeping and transmit event FIFO registers of a CAN controller.
// Assumes the transmit scan and protocol engine drive the engine struct synchronously to core_clk_in.
`timescale 1ns/1ps
module trf_tx_request_event_fifo
(
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire trf_pkg::trf_bus_req_t bus_in,
    output logic [31:0] rdata_out,
    input wire logic [31:0] buf_config_in,
    input wire logic no_auto_retransmit_mode_in,
    input wire trf_pkg::trf_engine_t engine_in,
    output logic [31:0] tx_pending_bits_out,
    output logic [31:0] add_request_bits_out,
    output logic [31:0] cancel_request_bits_out,
    output trf_pkg::trf_fifo_view_t fifo_out,
    output logic tx_done_irq_out,
    output logic cancel_done_irq_out
);
    import trf_pkg::*;

    // All state of the block, registered in one place.
    typedef struct packed {
        logic [31:0] add_req;
        logic [31:0] cancel_req;
        logic [31:0] pending;
        logic [31:0] tdone;
        logic [31:0] cdone;
        logic [31:0] transmit_done_irq_en;
        logic [31:0] cie;
        logic [5:0] wm;
        logic [5:0] size;
        logic [13:0] base;
        logic [4:0] put;
        logic [4:0] get;
        logic [4:0] ack;
        logic [5:0] fill;
        logic lost;
        logic full;
        logic wm_hit;
        logic tirq;
        logic cirq;
        logic [31:0] rdata;
    } trf_state_t;

    trf_state_t s_r;
    trf_state_t s_nxt;

    // Next index around a ring of sz elements; a disabled ring stays at zero.
    function automatic logic [4:0] trf_inc(input logic [4:0] idx, input logic [5:0] sz);
        logic [5:0] t;
        t = {1'b0, idx} + 6'h01;
        if (t >= sz)
        begin
            return 5'h00;
        end
        return t[4:0];
    endfunction : trf_inc

    // Elements held between get and put around the ring.
    function automatic logic [5:0] trf_level(input logic [4:0] p, input logic [4:0] g, input logic [5:0] sz);
        logic [6:0] t;
        if (p >= g)
        begin
            t = {2'b00, p} - {2'b00, g};
        end
        else
        begin
            t = {2'b00, p} + {1'b0, sz} - {2'b00, g};
        end
        return t[5:0];
    endfunction : trf_level

    // Address decode of one register strobe.
    function automatic logic trf_hit(input logic strobe, input logic [11:0] addr, input logic [11:0] ofs);
        logic h;
        h = 1'b0;
        if (strobe && addr == ofs)
        begin
            h = 1'b1;
        end
        return h;
    endfunction : trf_hit

    // Ring size in use; anything above the maximum acts as the maximum.
    function automatic logic [5:0] trf_clip_size(input logic [5:0] size);
        logic [5:0] c;
        c = size;
        if (size > TRF_EVT_MAX)
        begin
            c = TRF_EVT_MAX;
        end
        return c;
    endfunction : trf_clip_size

    // The watermark is live only for settings from one up to the maximum.
    function automatic logic trf_wm_reached(input logic [5:0] wm, input logic [5:0] fill);
        logic r;
        r = 1'b0;
        if (wm != 6'h00 && wm <= TRF_EVT_MAX)
        begin
            r = (fill >= wm);
        end
        return r;
    endfunction : trf_wm_reached

    // Read view of the event FIFO configuration.
    function automatic logic [31:0] trf_cfg_word(input logic [5:0] wm, input logic [5:0] size, input logic [13:0] base);
        logic [31:0] w;
        w = TRF_RST_WORD;
        w[TRF_WM_LSB +: 6] = wm;
        w[TRF_SIZE_LSB +: 6] = size;
        w[TRF_BASE_LSB +: 14] = base;
        return w;
    endfunction : trf_cfg_word

    // Read view of the event FIFO state.
    function automatic logic [31:0] trf_state_word(input logic lost, input logic full, input logic [4:0] put,
        input logic [4:0] get, input logic [5:0] fill);
        logic [31:0] w;
        w = TRF_RST_WORD;
        w[TRF_LOST_BIT] = lost;
        w[TRF_FULL_BIT] = full;
        w[TRF_PUT_LSB +: 5] = put;
        w[TRF_GET_LSB +: 5] = get;
        w[TRF_FILL_LSB +: 6] = fill;
        return w;
    endfunction : trf_state_word

    // Read view of the last acknowledged index.
    function automatic logic [31:0] trf_ack_word(input logic [4:0] ack);
        logic [31:0] w;
        w = TRF_RST_WORD;
        w[TRF_ACK_LSB +: 5] = ack;
        return w;
    endfunction : trf_ack_word

    // Add bits land only on configured buffers that are neither pending nor queued.
    function automatic logic [31:0] trf_take_add(input logic [31:0] wdata, input logic [31:0] cfg,
        input logic [31:0] pend, input logic [31:0] queued);
        return wdata & cfg & ~pend & ~queued;
    endfunction : trf_take_add

    // Full once the fill level reaches the size of an enabled ring.
    function automatic logic trf_is_full(input logic [5:0] fill, input logic [5:0] sz);
        return (sz != 6'h00) && (fill >= sz);
    endfunction : trf_is_full

    // Fill level after an acknowledge; equal indices with a store in the same cycle mean full.
    function automatic logic [5:0] trf_ack_fill(input logic [4:0] p, input logic [4:0] g, input logic [5:0] sz,
        input logic store);
        logic [5:0] f;
        f = trf_level(p, g, sz);
        if (f == 6'h00 && store)
        begin
            f = sz;
        end
        return f;
    endfunction : trf_ack_fill

    // An interrupt condition is any flag whose enable is set.
    function automatic logic trf_any(input logic [31:0] flags, input logic [31:0] en);
        return |(flags & en);
    endfunction : trf_any

    // Read data of one register; unmapped addresses read zero.
    function automatic logic [31:0] trf_read_word(input logic [11:0] addr, input trf_state_t st);
        logic [31:0] w;
        w = TRF_RST_WORD;
        unique case (addr)
            TRF_OFS_PENDING: w = st.pending;
            TRF_OFS_ADD_REQ: w = st.add_req;
            TRF_OFS_CANCEL_REQ: w = st.cancel_req;
            TRF_OFS_TX_OCCURRED: w = st.tdone;
            TRF_OFS_CANCEL_FIN: w = st.cdone;
            TRF_OFS_DONE_IRQ_EN: w = st.transmit_done_irq_en;
            TRF_OFS_CANCEL_IRQ_EN: w = st.cie;
            TRF_OFS_EVT_CONFIG: w = trf_cfg_word(st.wm, st.size, st.base);
            TRF_OFS_EVT_STATE: w = trf_state_word(st.lost, st.full, st.put, st.get, st.fill);
            TRF_OFS_EVT_ACK: w = trf_ack_word(st.ack);
            default: w = TRF_RST_WORD;
        endcase
        return w;
    endfunction : trf_read_word

    logic hit_add;
    logic hit_cancel;
    logic hit_tie;
    logic hit_cie;
    logic hit_cfg;
    logic hit_ack;
    logic evt_store;
    logic evt_refused;
    logic [4:0] ack_idx;
    logic [31:0] add_w;
    logic [31:0] can_w;
    logic [31:0] p;
    logic [31:0] cr;
    logic [31:0] clr_ok;
    logic [31:0] clr_fail;
    logic [31:0] clr_idle;
    logic [31:0] clr_all;
    logic [31:0] cancel_set;
    logic [31:0] cancel_now;
    logic [31:0] start_idle;
    logic [5:0] sz;

    always_comb
    begin
        // Everything holds unless a rule below changes it.
        s_nxt = s_r;
        s_nxt.rdata = TRF_RST_WORD;
        // Register strobes are decoded once per cycle.
        sz = trf_clip_size(s_r.size);
        hit_add = trf_hit(bus_in.wr, bus_in.addr, TRF_OFS_ADD_REQ);
        hit_cancel = trf_hit(bus_in.wr, bus_in.addr, TRF_OFS_CANCEL_REQ);
        hit_tie = trf_hit(bus_in.wr, bus_in.addr, TRF_OFS_DONE_IRQ_EN);
        hit_cie = trf_hit(bus_in.wr, bus_in.addr, TRF_OFS_CANCEL_IRQ_EN);
        hit_cfg = trf_hit(bus_in.wr, bus_in.addr, TRF_OFS_EVT_CONFIG);
        hit_ack = trf_hit(bus_in.wr, bus_in.addr, TRF_OFS_EVT_ACK);
        ack_idx = bus_in.wdata[TRF_ACK_LSB +: 5];
        evt_store = engine_in.evt_write && sz != 6'h00 && !s_r.full;
        evt_refused = engine_in.evt_write && !evt_store;

        // Writing zero leaves a request bit as it is.
        add_w = '0;
        if (hit_add)
        begin
            add_w = trf_take_add(bus_in.wdata, buf_config_in, s_r.pending, s_r.add_req);
        end
        can_w = '0;
        if (hit_cancel)
        begin
            can_w = bus_in.wdata & buf_config_in;
        end

        // Clears first so that completions in the same cycle win.
        s_nxt.tdone = s_r.tdone & ~add_w;
        s_nxt.cdone = s_r.cdone & ~add_w;
        s_nxt.add_req = s_r.add_req | add_w;
        s_nxt.cancel_req = s_r.cancel_req | can_w;

        // Queued adds enter the pending set only between scans.
        p = s_r.pending;
        if (!engine_in.scan_busy)
        begin
            p = s_r.pending | s_r.add_req;
            s_nxt.add_req = add_w;
        end

        // A cancel of a frame on the bus waits for its end, whatever the outcome.
        cr = s_nxt.cancel_req;
        start_idle = p & ~engine_in.started;
        clr_ok = engine_in.done_ok & p;
        // Failed frames clear only when a cancel is asked or retransmission is off.
        clr_fail = engine_in.done_fail & p & (cr | {32{no_auto_retransmit_mode_in}});
        clr_idle = cr & start_idle;
        clr_all = clr_ok | clr_fail | clr_idle;
        cancel_set = (clr_ok & cr) | clr_fail | clr_idle;
        cancel_now = cr & ~p;
        s_nxt.pending = p & ~clr_all;
        s_nxt.tdone = s_nxt.tdone | clr_ok;
        s_nxt.cdone = s_nxt.cdone | cancel_set | cancel_now;
        s_nxt.add_req = s_nxt.add_req & ~cr;
        s_nxt.cancel_req = cr & s_nxt.pending;

        // Plain read-write registers.
        if (hit_tie)
        begin
            s_nxt.transmit_done_irq_en = bus_in.wdata;
        end
        if (hit_cie)
        begin
            s_nxt.cie = bus_in.wdata;
        end
        if (hit_cfg)
        begin
            s_nxt.wm = bus_in.wdata[TRF_WM_LSB +: 6];
            s_nxt.size = bus_in.wdata[TRF_SIZE_LSB +: 6];
            s_nxt.base = bus_in.wdata[TRF_BASE_LSB +: 14];
        end

        // A refused event write in the same cycle as the clear wins.
        if (engine_in.lost_clear)
        begin
            s_nxt.lost = 1'b0;
        end
        if (evt_refused)
        begin
            s_nxt.lost = 1'b1;
        end
        if (evt_store)
        begin
            s_nxt.put = trf_inc(s_r.put, sz);
            s_nxt.fill = s_r.fill + 6'h01;
        end
        if (hit_ack)
        begin
            s_nxt.ack = ack_idx;
            s_nxt.get = trf_inc(ack_idx, sz);
            s_nxt.fill = trf_ack_fill(s_nxt.put, s_nxt.get, sz, evt_store);
        end

        // Full and watermark follow the fill level of the next cycle.
        s_nxt.full = trf_is_full(s_nxt.fill, sz);
        s_nxt.wm_hit = trf_wm_reached(s_r.wm, s_nxt.fill);

        // Interrupt conditions go out in the same cycle as their flags.
        s_nxt.tirq = trf_any(s_nxt.tdone, s_nxt.transmit_done_irq_en);
        s_nxt.cirq = trf_any(s_nxt.cdone, s_nxt.cie);

        // Read data stands for one cycle and is zero otherwise.
        if (bus_in.rd)
        begin
            s_nxt.rdata = trf_read_word(bus_in.addr, s_r);
        end
    end

    // Reset clears every register, outputs included.
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Every output is a register of the state struct.
    assign rdata_out = s_r.rdata;
    assign tx_pending_bits_out = s_r.pending;
    assign add_request_bits_out = s_r.add_req;
    assign cancel_request_bits_out = s_r.cancel_req;
    assign fifo_out = trf_fifo_view_t'{
        base: s_r.base,
        put: s_r.put,
        full: s_r.full,
        lost: s_r.lost,
        watermark: s_r.wm_hit
    };
    assign tx_done_irq_out = s_r.tirq;
    assign cancel_done_irq_out = s_r.cirq;

endmodule : trf_tx_request_event_fifo

// ==== hdl/trf_pkg.sv ====
// Constants, register map and carrier types of the transmit request and event FIFO block.
// Assumes one 250 MHz clock and a simple strobe-based register port with 32-bit data.
package trf_pkg;

    localparam int TRF_NBUF = 32;
    localparam int TRF_AW = 12;
    localparam int TRF_DW = 32;

    localparam logic [11:0] TRF_OFS_PENDING = 12'h0cc;
    localparam logic [11:0] TRF_OFS_ADD_REQ = 12'h0d0;
    localparam logic [11:0] TRF_OFS_CANCEL_REQ = 12'h0d4;
    localparam logic [11:0] TRF_OFS_TX_OCCURRED = 12'h0d8;
    localparam logic [11:0] TRF_OFS_CANCEL_FIN = 12'h0dc;
    localparam logic [11:0] TRF_OFS_DONE_IRQ_EN = 12'h0e0;
    localparam logic [11:0] TRF_OFS_CANCEL_IRQ_EN = 12'h0e4;
    localparam logic [11:0] TRF_OFS_EVT_CONFIG = 12'h0f0;
    localparam logic [11:0] TRF_OFS_EVT_STATE = 12'h0f4;
    localparam logic [11:0] TRF_OFS_EVT_ACK = 12'h0f8;

    localparam int TRF_WM_LSB = 24;
    localparam int TRF_SIZE_LSB = 16;
    localparam int TRF_BASE_LSB = 2;
    localparam int TRF_LOST_BIT = 25;
    localparam int TRF_FULL_BIT = 24;
    localparam int TRF_PUT_LSB = 16;
    localparam int TRF_GET_LSB = 8;
    localparam int TRF_FILL_LSB = 0;
    localparam int TRF_ACK_LSB = 0;

    localparam logic [5:0] TRF_EVT_MAX = 6'h20;
    localparam logic [31:0] TRF_RST_WORD = 32'h0000_0000;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } trf_bus_req_t;

    typedef struct packed {
        logic scan_busy;
        logic [31:0] started;
        logic [31:0] done_ok;
        logic [31:0] done_fail;
        logic evt_write;
        logic lost_clear;
    } trf_engine_t;

    typedef struct packed {
        logic [13:0] base;
        logic [4:0] put;
        logic full;
        logic lost;
        logic watermark;
    } trf_fifo_view_t;

endpackage : trf_pkg

// ==== tb/trf_props.sv ====
// Port-level checks of the transmit request and event FIFO block.
// Assumes it is bound to the block's top module.
`timescale 1ns/1ps
module trf_props
(
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire trf_pkg::trf_bus_req_t bus_in,
    input wire logic [31:0] buf_config_in,
    input wire trf_pkg::trf_engine_t engine_in,
    input wire logic [31:0] tx_pending_bits_out,
    input wire logic [31:0] add_request_bits_out,
    input wire logic [31:0] cancel_request_bits_out,
    input wire trf_pkg::trf_fifo_view_t fifo_out
);
    import trf_pkg::*;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    req_cfg_a: assert property (((add_request_bits_out | cancel_request_bits_out) & ~$past(add_request_bits_out |
        cancel_request_bits_out) & ~$past(buf_config_in)) == 32'h0000_0000) else $error("unconfigured request set");
    add_pend_a: assert property ((add_request_bits_out & tx_pending_bits_out) == 32'h0000_0000)
        else $error("add and pending together");
    add_idle_a: assert property (add_request_bits_out != 0 && !engine_in.scan_busy |=>
        (add_request_bits_out & $past(add_request_bits_out)) == 32'h0000_0000) else $error("add bit kept while idle");
    pend_src_a: assert property ((tx_pending_bits_out & ~$past(tx_pending_bits_out)
        & ~$past(add_request_bits_out)) == 32'h0000_0000) else $error("pending set without add");
    done_clr_a: assert property ((engine_in.done_ok & tx_pending_bits_out) != 0 |=>
        (tx_pending_bits_out & $past(engine_in.done_ok)) == 32'h0000_0000) else $error("pending kept after done");
    cancel_hold_a: assert property ((($past(cancel_request_bits_out) & ~cancel_request_bits_out)
        & tx_pending_bits_out) == 32'h0000_0000) else $error("cancel dropped while pending");
    base_wr_a: assert property (bus_in.wr && bus_in.addr == TRF_OFS_EVT_CONFIG |=>
        fifo_out.base == $past(bus_in.wdata[15:2])) else $error("base not taken");
    put_cause_a: assert property (fifo_out.put != $past(fifo_out.put) |-> $past(engine_in.evt_write))
        else $error("put moved without write");
    full_lost_a: assert property (engine_in.evt_write && fifo_out.full && !bus_in.wr |=>
        fifo_out.lost && $stable(fifo_out.put)) else $error("write into full fifo");
    lost_hold_a: assert property (fifo_out.lost && !engine_in.lost_clear |=> fifo_out.lost)
        else $error("lost flag dropped");
endmodule : trf_props
bind trf_tx_request_event_fifo trf_props trf_props_i (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .bus_in(bus_in), .buf_config_in(buf_config_in), .engine_in(engine_in), .fifo_out(fifo_out),
    .tx_pending_bits_out(tx_pending_bits_out), .add_request_bits_out(add_request_bits_out),
    .cancel_request_bits_out(cancel_request_bits_out));

// ==== tb/test_tx_request_event_fifo.sv ====
// Directed register test of the transmit request and event FIFO block.
// Assumes buffers 0 to 7 configured and the engine driven by the bench.
`timescale 1ns/1ps
module test_tx_request_event_fifo;
    import trf_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    trf_bus_req_t bus = '0;
    trf_engine_t eng = '0;
    logic nar = 1'b0;
    logic [31:0] rdata, pend, addb, canb;
    trf_fifo_view_t fv;
    logic tirq, cirq;
    int n_fail = 0;
    int n_tests = 0;
    trf_tx_request_event_fifo trf_tx_request_event_fifo_i
    (
        .core_clk_in(clk), .sys_rst_in(rst), .bus_in(bus), .rdata_out(rdata), .buf_config_in(32'h0000_00ff),
        .no_auto_retransmit_mode_in(nar), .engine_in(eng), .tx_pending_bits_out(pend),
        .add_request_bits_out(addb), .cancel_request_bits_out(canb), .fifo_out(fv),
        .tx_done_irq_out(tirq), .cancel_done_irq_out(cirq)
    );
    initial forever #2 clk = ~clk;
    task finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge clk);
        bus <= '0;
    endtask : acc
    task rd(input logic [11:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0000_0000);
        #1 cmp(rdata, e);
    endtask : rd
    task pulse(input logic [31:0] ok, input logic [31:0] fl, input logic ev);
        @(posedge clk);
        eng.done_ok <= ok;
        eng.done_fail <= fl;
        eng.evt_write <= ev;
        @(posedge clk);
        eng.done_ok <= '0;
        eng.done_fail <= '0;
        eng.evt_write <= 1'b0;
        #1;
    endtask : pulse
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(TRF_OFS_CANCEL_FIN, 32'h0000_0000);
        rd(12'h0fc, 32'h0000_0000);
        acc(1'b1, TRF_OFS_ADD_REQ, 32'h0000_0f03);
        #1 cmp(addb, 32'h0000_0003);
        rd(TRF_OFS_PENDING, 32'h0000_0003);
        acc(1'b1, TRF_OFS_DONE_IRQ_EN, 32'h0000_0001);
        rd(TRF_OFS_DONE_IRQ_EN, 32'h0000_0001);
        pulse(32'h0000_0001, 32'h0000_0000, 1'b0);
        cmp({31'h0, tirq}, 32'h0000_0001);
        rd(TRF_OFS_TX_OCCURRED, 32'h0000_0001);
        acc(1'b1, TRF_OFS_ADD_REQ, 32'h0000_0003);
        #1 cmp(addb, 32'h0000_0001);
        rd(TRF_OFS_TX_OCCURRED, 32'h0000_0000);
        $display("add and done test ended");
        acc(1'b1, TRF_OFS_CANCEL_IRQ_EN, 32'h0000_0010);
        acc(1'b1, TRF_OFS_CANCEL_REQ, 32'h0000_0010);
        #1 cmp(canb, 32'h0000_0000);
        rd(TRF_OFS_CANCEL_FIN, 32'h0000_0010);
        cmp({31'h0, cirq}, 32'h0000_0001);
        @(posedge clk);
        eng.started <= 32'h0000_0002;
        acc(1'b1, TRF_OFS_CANCEL_REQ, 32'h0000_0002);
        repeat (3) @(posedge clk);
        #1 cmp(canb & pend, 32'h0000_0002);
        cmp(canb, 32'h0000_0002);
        pulse(32'h0000_0000, 32'h0000_0002, 1'b0);
        cmp(canb | pend, 32'h0000_0001);
        @(posedge clk);
        eng.started <= '0;
        rd(TRF_OFS_CANCEL_FIN, 32'h0000_0012);
        $display("cancel test ended");
        @(posedge clk);
        eng.scan_busy <= 1'b1;
        acc(1'b1, TRF_OFS_ADD_REQ, 32'h0000_0004);
        repeat (3) @(posedge clk);
        #1 cmp(addb | pend, 32'h0000_0005);
        @(posedge clk);
        eng.scan_busy <= 1'b0;
        repeat (3) @(posedge clk);
        #1 cmp(pend, 32'h0000_0005);
        @(posedge clk);
        nar <= 1'b1;
        pulse(32'h0000_0000, 32'h0000_0004, 1'b0);
        cmp(pend, 32'h0000_0001);
        rd(TRF_OFS_CANCEL_FIN, 32'h0000_0016);
        $display("scan and retransmit test ended");
        acc(1'b1, TRF_OFS_EVT_CONFIG, 32'h0202_48d0);
        rd(TRF_OFS_EVT_CONFIG, 32'h0202_48d0);
        pulse(32'h0000_0000, 32'h0000_0000, 1'b1);
        pulse(32'h0000_0000, 32'h0000_0000, 1'b1);
        rd(TRF_OFS_EVT_STATE, 32'h0100_0002);
        cmp({31'h0, fv.watermark}, 32'h0000_0001);
        pulse(32'h0000_0000, 32'h0000_0000, 1'b1);
        rd(TRF_OFS_EVT_STATE, 32'h0300_0002);
        acc(1'b1, TRF_OFS_EVT_ACK, 32'h0000_0000);
        rd(TRF_OFS_EVT_STATE, 32'h0200_0101);
        @(posedge clk);
        eng.lost_clear <= 1'b1;
        @(posedge clk);
        eng.lost_clear <= 1'b0;
        rd(TRF_OFS_EVT_STATE, 32'h0000_0101);
        $display("event fifo test ended");
        finish_test();
    end
    initial
    begin
        repeat (2000) @(posedge clk);
        n_fail++;
        finish_test();
    end
endmodule : test_tx_request_event_fifo
